// ### hdl/pstage_pkg.sv
// constants, modes and carriers of the programmable stage
package pstage_pkg;
    // ------------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------------
    localparam int NCH         = 3;
    localparam int LOG_DEPTH   = 12;
    localparam int CLK_NS      = 10;
    localparam int MS_NS       = 1000000;
    localparam int MS_CYC      = MS_NS / CLK_NS;
    localparam int WIN_MS      = 20;
    localparam int MAX_TRIP_MS = 1800000;
    localparam int BP_FULL     = 10000;
    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_MODE   = 8'h04;
    localparam logic [7:0] A_PICK0  = 8'h08;
    localparam logic [7:0] A_HYST0  = 8'h14;
    localparam logic [7:0] A_BLIM   = 8'h20;
    localparam logic [7:0] A_OPDLY  = 8'h24;
    localparam logic [7:0] A_RLDLY  = 8'h28;
    localparam logic [7:0] A_EVMASK = 8'h2C;
    localparam logic [7:0] A_STAT   = 8'h30;
    localparam logic [7:0] A_CNT0   = 8'h34;
    localparam logic [7:0] A_LOGSEL = 8'h40;
    localparam logic [7:0] A_LOGTSL = 8'h44;
    localparam logic [7:0] A_LOGTSH = 8'h48;
    localparam logic [7:0] A_LOGMAG = 8'h4C;
    localparam logic [7:0] A_LOGRAT = 8'h50;
    localparam logic [7:0] A_LOGINF = 8'h54;
    localparam logic [7:0] A_TREM   = 8'h58;
    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int F_NCH   = 0;
    localparam int F_BLEN  = 2;
    localparam int F_CLR   = 3;
    localparam int F_MODE  = 4;
    localparam logic [1:0]  NCH_RST    = 2'h1;
    localparam logic [31:0] PICK_RST   = 32'h0000_0001;
    localparam logic [15:0] HYST_RST   = 16'h012C;
    localparam logic [31:0] OPDLY_RST  = 32'h0000_0028;
    localparam logic [31:0] RLDLY_RST  = 32'h0000_003C;
    localparam logic [5:0]  EVMASK_RST = 6'h3F;
    // event flag positions
    localparam int EV_START_ON = 0;
    localparam int EV_START_OF = 1;
    localparam int EV_TRIP_ON  = 2;
    localparam int EV_TRIP_OF  = 3;
    localparam int EV_BLK_ON   = 4;
    localparam int EV_BLK_OF   = 5;
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        M_OVER, M_OVER_ABS, M_UNDER, M_UNDER_ABS,
        M_DREL, M_DREL_ABS, M_DVAL, M_DVAL_ABS
    } cmp_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE, ST_RUN, ST_REL, ST_BLOCKED
    } stg_state_t;
    typedef struct packed {
        logic [NCH-1:0][31:0] val;
    } meas_t;
    typedef struct packed {
        logic [47:0] ts;
        logic [5:0]  flags;
    } evt_t;
    typedef struct packed {
        logic [47:0] ts;
        logic [1:0]  id;
        logic [31:0] mag;
        logic [31:0] ratio;
        logic [20:0] trem;
        logic [2:0]  sg;
    } rec_t;
endpackage

// ### hdl/programmable_stage.sv
// programmable comparator stage with timing, events, counters and log
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - over mode picks up when signed value exceeds pick-up level.
// - absolute over picks up when magnitude exceeds pick-up level.
// - under mode picks up below level; inactive below blocking limit.
// - absolute under picks up on small magnitude; suppressed below limit.
// - signed relative delta: directed change beyond percent within 20 ms.
// - absolute relative delta: change beyond percent within 20 ms.
// - signed value delta: directed change beyond amount within 20 ms.
// - absolute value delta: change beyond amount either way in 20 ms.
// - each comparison owns signed level and hysteresis, default 3 %.
// - operate and release delays are set independently.
// - blocking input is sampled at each program cycle before pick-up.
// - pick-up without blocking raises start and begins operate timing.
// - pick-up while blocked raises blocked, no timing or trip.
// - late blocking clears start and runs release handling.
// - start, trip, block ON/OFF events pass through per-event masks.
// - every event carries a time stamp.
// - start, trip and blocked counters, each resettable.
// - rolling log of twelve records taken on ON transitions only.
// - record holds time, event, magnitude, ratio, remaining time, group.
// - one to three measurements, each with its own pick-up.
// - release threshold is pick-up offset by hysteresis of that level.
module programmable_stage
    import pstage_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYC
) (
    // clock, reset, enable
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic        ce_i,
    // measurement side
    input  wire logic        cyc_i,
    input  wire meas_t       meas_i,
    input  wire logic        block_i,
    input  wire logic [47:0] ts_i,
    input  wire logic [2:0]  sg_i,
    // register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // stage outputs
    output logic             start_o,
    output logic             trip_o,
    output logic             blocked_o,
    output evt_t             evt_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]               nch;
        logic                     blen;
        logic [NCH-1:0][2:0]      mode;
        logic [NCH-1:0][31:0]     pick;
        logic [NCH-1:0][15:0]     hyst;
        logic [31:0]              blim;
        logic [31:0]              opdly;
        logic [31:0]              rldly;
        logic [5:0]               evmask;
        logic [3:0]               logsel;
        logic [31:0]              ms_cnt;
        logic [4:0]               win_cnt;
        logic [NCH-1:0][31:0]     refv;
        logic [NCH-1:0]           pk;
        logic                     blk_s;
        logic                     eval;
        stg_state_t               state;
        logic                     start;
        logic                     trip;
        logic                     blocked;
        logic [31:0]              op_cnt;
        logic [31:0]              rel_cnt;
        logic [2:0][31:0]         cnt;
        evt_t                     evt;
        logic                     ref_ok;
        rec_t [LOG_DEPTH-1:0]     log;
        logic [3:0]               wp;
        logic [3:0]               lcnt;
        logic [31:0]              rdata;
    } st_t;

    st_t q;
    st_t d;

    // ------------------------------------------------------------------
    // one comparison with hysteresis
    // ------------------------------------------------------------------
    function automatic logic eval_ch(
        input logic [2:0]  md,
        input logic [31:0] mv,
        input logic [31:0] rv,
        input logic [31:0] ps,
        input logic [15:0] hy,
        input logic        prev,
        input logic        ben,
        input logic [31:0] bl
    );
        logic signed [63:0] m;
        logic signed [63:0] dl;
        logic signed [63:0] x;
        logic signed [63:0] thr;
        logic signed [63:0] h;
        logic signed [63:0] r;
        logic               gt;
        logic               inh;
        logic               on;
        logic               off;
        m   = 64'($signed(mv));
        dl  = m - 64'($signed(rv));
        r   = ($signed(rv) < 0) ? -64'($signed(rv)) : 64'($signed(rv));
        thr = 64'($signed(ps));
        x   = m;
        gt  = 1'b1;
        inh = 1'b0;
        case (cmp_mode_t'(md))
            M_OVER: x = m;
            M_OVER_ABS: x = (m < 0) ? -m : m;
            M_UNDER: begin
                gt  = 1'b0;
                inh = ben && (m < 64'($signed(bl)));
            end
            M_UNDER_ABS: begin
                x   = (m < 0) ? -m : m;
                gt  = 1'b0;
                inh = ben && (m < 64'($signed(bl)));
            end
            M_DREL: begin
                x   = dl * 64'(BP_FULL);
                gt  = (thr >= 0);
                thr = thr * r;
            end
            M_DREL_ABS: begin
                x   = ((dl < 0) ? -dl : dl) * 64'(BP_FULL);
                thr = thr * r;
            end
            M_DVAL: begin
                x  = dl;
                gt = (thr >= 0);
            end
            M_DVAL_ABS: x = (dl < 0) ? -dl : dl;
            default: x = m;
        endcase
        // band scales with the level itself
        h   = (((thr < 0) ? -thr : thr) * 64'(hy)) / 64'(BP_FULL);
        on  = gt ? (x > thr) : (x < thr);
        off = gt ? (x <= thr - h) : (x >= thr + h);
        return inh ? 1'b0 : (prev ? !off : on);
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic              tick;
    logic              pick;
    logic [NCH-1:0]    pk_n;
    logic [2:0]        clr;
    logic [2:0]        inc;
    logic [5:0]        ev;
    logic [4:0]        ridx;
    logic [20:0]       trem;
    logic [31:0]       mag;
    logic [31:0]       setv;
    rec_t              rr;

    always_comb begin
        d    = q;
        tick = (q.ms_cnt == 32'(MS_CYCLES - 1));
        clr  = '0;
        pk_n = q.pk;
        // millisecond base and 20 ms reference window
        d.ms_cnt = tick ? '0 : q.ms_cnt + 32'h0000_0001;
        if (tick) begin
            d.win_cnt = q.win_cnt + 5'h01;
            if (q.win_cnt == 5'(WIN_MS - 1)) begin
                d.win_cnt = '0;
                d.refv    = meas_i.val;
                d.ref_ok  = 1'b1;
            end
        end
        // block level latched at cycle start, evaluated next edge
        d.eval = cyc_i;
        if (cyc_i) begin
            d.blk_s = block_i;
        end
        // only the selected number of channels take part
        // each channel its own level and band
        for (int i = 0; i < NCH; i++) begin
            if (q.eval) begin
                // delta modes stay quiet until a first reference exists
                pk_n[i] = (i < int'(q.nch)) &&
                    (q.ref_ok || !q.mode[i][2]) && eval_ch(q.mode[i],
                    meas_i.val[i], q.refv[i], q.pick[i], q.hyst[i],
                    q.pk[i], q.blen, q.blim);
            end
        end
        d.pk = pk_n;
        pick = |pk_n;
        if (tick && q.state == ST_RUN && q.op_cnt != '1) begin
            d.op_cnt = q.op_cnt + 32'h0000_0001;
        end
        if (tick && q.state == ST_REL && q.rel_cnt != '1) begin
            d.rel_cnt = q.rel_cnt + 32'h0000_0001;
        end
        if (q.eval) begin
            case (q.state)
                ST_IDLE: begin
                    if (pick && !q.blk_s) begin
                        d.state  = ST_RUN;
                        d.start  = 1'b1;
                        d.op_cnt = '0;
                    end else if (pick) begin
                        d.state   = ST_BLOCKED;
                        d.blocked = 1'b1;
                    end
                end
                ST_RUN: begin
                    if (!pick || q.blk_s) begin
                        d.state   = ST_REL;
                        d.rel_cnt = '0;
                        d.start   = !q.blk_s;
                    end else if (q.op_cnt > q.opdly) begin
                        // first tick may come early, so one more
                        d.trip = 1'b1;
                    end
                end
                ST_REL: begin
                    if (pick && !q.blk_s) begin
                        d.state = ST_RUN;
                        d.start = 1'b1;
                    end else if (q.rel_cnt > q.rldly) begin
                        // release only past a full release delay
                        d.state = ST_IDLE;
                        d.start = 1'b0;
                        d.trip  = 1'b0;
                    end
                end
                ST_BLOCKED: begin
                    if (!pick || !q.blk_s) begin
                        d.state   = ST_IDLE;
                        d.blocked = 1'b0;
                    end
                end
                default: d.state = ST_IDLE;
            endcase
        end
        // ON and OFF edges, masked per event
        ev[EV_START_ON] = d.start && !q.start;
        ev[EV_START_OF] = !d.start && q.start;
        ev[EV_TRIP_ON]  = d.trip && !q.trip;
        ev[EV_TRIP_OF]  = !d.trip && q.trip;
        ev[EV_BLK_ON]   = d.blocked && !q.blocked;
        ev[EV_BLK_OF]   = !d.blocked && q.blocked;
        d.evt.flags = ev & q.evmask;
        d.evt.ts = ts_i;
        // remaining operate time, capped
        trem = '0;
        if (q.state == ST_RUN && q.opdly > q.op_cnt) begin
            trem = ((q.opdly - q.op_cnt) > 32'(MAX_TRIP_MS)) ?
                21'(MAX_TRIP_MS) : 21'(q.opdly - q.op_cnt);
        end
        // magnitude of the lowest picked channel
        mag  = meas_i.val[0];
        setv = q.pick[0];
        for (int i = NCH - 1; i >= 0; i--) begin
            if (pk_n[i]) begin
                mag  = meas_i.val[i];
                setv = q.pick[i];
            end
        end
        rr.ts    = ts_i;
        rr.id    = ev[EV_BLK_ON] ? 2'h3 : (ev[EV_TRIP_ON] ? 2'h2 : 2'h1);
        rr.mag   = mag;
        rr.ratio = (setv == '0) ? '0 : 32'(($signed(64'($signed(mag)))
                   <<< 8) / $signed(64'($signed(setv))));
        rr.trem  = trem;
        rr.sg    = sg_i;
        // ring of twelve, ON edges only
        if (ev[EV_START_ON] || ev[EV_TRIP_ON] || ev[EV_BLK_ON]) begin
            d.log[q.wp] = rr;
            d.wp = (q.wp == 4'(LOG_DEPTH - 1)) ? '0 : q.wp + 4'h1;
            if (q.lcnt != 4'(LOG_DEPTH)) begin
                d.lcnt = q.lcnt + 4'h1;
            end
        end
        // register writes
        if (wr_i) begin
            case (addr_i)
                A_CTRL: begin
                    d.nch  = wdata_i[F_NCH +: 2];
                    d.blen = wdata_i[F_BLEN];
                    clr    = wdata_i[F_CLR +: 3];
                end
                A_MODE: begin
                    for (int i = 0; i < NCH; i++) begin
                        d.mode[i] = wdata_i[F_MODE*i +: 3];
                    end
                end
                A_BLIM:   d.blim   = wdata_i;
                A_OPDLY:  d.opdly  = wdata_i;
                A_RLDLY:  d.rldly  = wdata_i;
                A_EVMASK: d.evmask = wdata_i[5:0];
                A_LOGSEL: d.logsel = wdata_i[3:0];
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (addr_i == A_PICK0 + 8'(4 * i)) begin
                            d.pick[i] = wdata_i;
                        end
                        if (addr_i == A_HYST0 + 8'(4 * i)) begin
                            d.hyst[i] = wdata_i[15:0];
                        end
                    end
                end
            endcase
        end
        // counters, a count in the clear cycle survives
        inc = {ev[EV_BLK_ON], ev[EV_TRIP_ON], ev[EV_START_ON]};
        for (int i = 0; i < 3; i++) begin
            if (inc[i]) begin
                d.cnt[i] = clr[i] ? 32'h0000_0001 : q.cnt[i] + 32'h0000_0001;
            end else if (clr[i]) begin
                d.cnt[i] = '0;
            end
        end
        // register reads, newest log entry at select zero
        ridx = 5'({1'b0, q.wp} + 5'(LOG_DEPTH) - 5'h01 - {1'b0, q.logsel});
        if (ridx >= 5'(LOG_DEPTH)) begin
            ridx = ridx - 5'(LOG_DEPTH);
        end
        rr = q.log[4'(ridx)];
        d.rdata = '0;
        if (rd_i) begin
            case (addr_i)
                A_CTRL:   d.rdata = 32'({q.blen, q.nch});
                A_MODE:   d.rdata = 32'({1'b0, q.mode[2], 1'b0,
                                         q.mode[1], 1'b0, q.mode[0]});
                A_BLIM:   d.rdata = q.blim;
                A_OPDLY:  d.rdata = q.opdly;
                A_RLDLY:  d.rdata = q.rldly;
                A_EVMASK: d.rdata = 32'(q.evmask);
                A_STAT:   d.rdata = 32'({q.pk, q.blocked, q.trip, q.start,
                                         q.state});
                A_LOGSEL: d.rdata = 32'({q.lcnt, q.logsel});
                A_LOGTSL: d.rdata = rr.ts[31:0];
                A_LOGTSH: d.rdata = 32'(rr.ts[47:32]);
                A_LOGMAG: d.rdata = rr.mag;
                A_LOGRAT: d.rdata = rr.ratio;
                A_LOGINF: d.rdata = 32'({rr.sg, rr.id, rr.trem});
                A_TREM:   d.rdata = 32'(trem);
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (addr_i == A_PICK0 + 8'(4 * i)) begin
                            d.rdata = q.pick[i];
                        end
                        if (addr_i == A_HYST0 + 8'(4 * i)) begin
                            d.rdata = 32'(q.hyst[i]);
                        end
                        if (addr_i == A_CNT0 + 8'(4 * i)) begin
                            d.rdata = q.cnt[i];
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            q        <= '0;
            q.nch    <= NCH_RST;
            q.pick   <= {NCH{PICK_RST}};
            q.hyst   <= {NCH{HYST_RST}};
            q.opdly  <= OPDLY_RST;
            q.rldly  <= RLDLY_RST;
            q.evmask <= EVMASK_RST;
        end else if (ce_i) begin
            q <= d;
        end
    end

    // outputs straight from state
    assign rdata_o   = q.rdata;
    assign start_o   = q.start;
    assign trip_o    = q.trip;
    assign blocked_o = q.blocked;
    assign evt_o     = q.evt;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    chk_block_latch: assert property (
        ce_i && cyc_i |=> q.blk_s == $past(block_i) && q.eval)
        else $error("block level not latched at cycle start");
    chk_start_free: assert property (
        $rose(start_o) |-> !$past(q.blk_s) && q.state == ST_RUN)
        else $error("start raised while blocked");
    chk_blocked_idle: assert property (
        blocked_o |-> !start_o && !trip_o && q.state == ST_BLOCKED)
        else $error("blocked stage is timing");
    chk_block_drop: assert property (
        ce_i && q.eval && q.blk_s && q.state == ST_RUN
        |=> !start_o && q.state == ST_REL)
        else $error("late block did not clear start");
    chk_event_mask: assert property (
        $past(ce_i) |-> (evt_o.flags & ~$past(q.evmask)) == 6'h00)
        else $error("masked event passed");
    chk_event_stamp: assert property (
        $past(ce_i) && (|evt_o.flags) |-> evt_o.ts == $past(ts_i))
        else $error("event stamp wrong");
    chk_start_count: assert property (
        ce_i && !start_o ##1 start_o |-> q.cnt[0] != 32'h0000_0000)
        else $error("start count missed");
    chk_log_depth: assert property (
        q.lcnt <= 4'(LOG_DEPTH) && q.wp < 4'(LOG_DEPTH))
        else $error("log ring out of range");
    chk_trip_delay: assert property (
        $rose(trip_o) |-> $past(q.op_cnt) > $past(q.opdly) && start_o)
        else $error("trip before operate delay");

endmodule

`default_nettype wire

// ### sim/pstage_far.sv
// far-side model: blocking source and start ON event counter
`timescale 1ns/100ps
`default_nettype none
module pstage_far
    import pstage_pkg::*;
(
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic nrst_i,
    // blocking side
    input  wire logic blk_req_i,
    output logic      block_o,
    // event side
    input  wire evt_t evt_i,
    output int        ons_o
);
    always_ff @(posedge mclk_i) begin
        block_o <= nrst_i & blk_req_i;
    end
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            ons_o <= 0;
        end else if (evt_i.flags[EV_START_ON]) begin
            ons_o <= ons_o + 1;
        end
    end
endmodule
`default_nettype wire

// ### sim/programmable_stage_tb_top.sv
// self-checking bench of the programmable stage
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    mismatches++; $display("MISMATCH t=%0t %h %h", $time, a, b); end end
module programmable_stage_tb_top;
    import pstage_pkg::*;
    logic        mclk_i = 0, nrst_i = 0, ce_i = 1, cyc_i = 0, blk = 0;
    logic        block_i, wr_i = 0, rd_i = 0, rd_q = 0;
    logic        start_o, trip_o, blocked_o;
    meas_t       meas_i = '0;
    logic [47:0] ts_i = '0;
    logic [2:0]  sg_i = '0;
    logic [7:0]  addr_i = '0;
    logic [31:0] wdata_i = '0, rdata_o, seed = 32'h27b9_d38a;
    logic [31:0] v0 = '0, exp_v;
    evt_t        evt_o;
    int          mismatches = 0, samples_checked = 0, ons, n;
    logic [31:0] expq[$];
    int md[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 0, 2};
    int pk[10] = '{100, 100, 100, 100, 1000, 1000, 50, 50, 100, 100};
    int bs[10] = '{0, 0, 500, 500, 1000, 1000, 0, 0, 0, 500};
    int sp[10] = '{200, -200, 50, -50, 2000, 0, 1000, -1000, 50, 50};
    programmable_stage #(.MS_CYCLES(10)) u_programmable_stage (
        .mclk_i, .nrst_i, .ce_i, .cyc_i, .meas_i, .block_i, .ts_i, .sg_i,
        .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .start_o, .trip_o,
        .blocked_o, .evt_o);
    pstage_far u_pstage_far (.mclk_i, .nrst_i, .blk_req_i(blk),
        .block_o(block_i), .evt_i(evt_o), .ons_o(ons));
    always #5 mclk_i = ~mclk_i;
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    // program cycles, stamps and random idle channels
    always @(posedge mclk_i) begin
        cyc_i <= nrst_i & ~cyc_i;
        seed <= xs(seed);
        ts_i <= ts_i + 48'h1;
        sg_i <= seed[2:0];
        meas_i.val[0] <= v0;
        meas_i.val[1] <= seed;
        meas_i.val[2] <= ~seed;
    end
    // read data taken one cycle after the strobe
    always @(posedge mclk_i) begin
        if (rd_q) begin
            exp_v = expq.pop_front();
            `CHK(rdata_o, exp_v)
        end
        rd_q <= rd_i;
    end
    task automatic tick(int k);
        repeat (k) @(posedge mclk_i);
    endtask
    task automatic final_report();
        $display("mismatches=%0d samples_checked=%0d", mismatches,
                 samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        tick(1);
        wr_i <= 1'b0;
        tick(1);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        expq.push_back(e);
        addr_i <= a;
        rd_i <= 1'b1;
        tick(1);
        rd_i <= 1'b0;
        tick(1);
    endtask
    // bounded wait: k 0 start, 1 trip, 2 blocked
    task automatic wait_for(int k, logic v, int lim, output int c);
        logic [2:0] o;
        c = 0;
        o = {blocked_o, trip_o, start_o};
        while (o[k] !== v && c < lim) begin
            tick(1);
            c++;
            o = {blocked_o, trip_o, start_o};
        end
        if (c >= lim) begin
            mismatches++;
            final_report();
        end
    endtask
    // reset, base value, mode and pick-up from the case tables
    task automatic setup(int i, int op);
        v0 <= 32'(bs[i]);
        nrst_i <= 1'b0;
        tick(3);
        nrst_i <= 1'b1;
        tick(1);
        wr(A_MODE, 32'(md[i]));
        wr(A_PICK0, 32'(pk[i]));
        wr(A_RLDLY, 32'h3);
        wr(A_OPDLY, 32'(op));
        wr(A_BLIM, 32'hc8);
        wr(A_CTRL, i == 9 ? 32'h5 : 32'h1);
        tick(450);
        `CHK(start_o, 1'b0)
        v0 <= 32'(sp[i] + int'(seed[4:0]));
    endtask
    initial begin
        tick(3);
        nrst_i <= 1'b1;
        tick(1);
        rd(A_PICK0, 32'h1);
        rd(A_HYST0, 32'h12c);
        rd(A_OPDLY, 32'h28);
        rd(A_RLDLY, 32'h3c);
        rd(A_EVMASK, 32'h3f);
        rd(8'h5c, 32'h0);
        // every comparator mode, two suppressed cases
        for (int i = 0; i < 10; i++) begin
            setup(i, 40);
            if (i < 8) begin
                wait_for(0, 1'b1, 400, n);
                `CHK(start_o, 1'b1)
                tick(3);
                `CHK(ons, 1)
                rd(A_CNT0, 32'h1);
                rd(A_LOGSEL, 32'h10);
                rd(A_LOGMAG, v0);
            end else begin
                tick(400);
                `CHK(start_o, 1'b0)
            end
        end
        // trip after 2 ms, release after 3 ms
        setup(0, 2);
        wait_for(0, 1'b1, 40, n);
        wait_for(1, 1'b1, 60, n);
        `CHK(n >= 20 && n <= 32, 1'b1)
        v0 <= 32'h0;
        wait_for(1, 1'b0, 80, n);
        `CHK(n >= 30 && n <= 47, 1'b1)
        `CHK(start_o, 1'b0)
        // late blocking cancels a running start
        setup(0, 40);
        wait_for(0, 1'b1, 40, n);
        blk <= 1'b1;
        tick(8);
        `CHK(start_o, 1'b0)
        tick(450);
        `CHK(trip_o, 1'b0)
        // blocked pick-up, counter clear, masked events
        setup(0, 2);
        wr(A_EVMASK, 32'h0);
        wait_for(2, 1'b1, 40, n);
        tick(40);
        `CHK({trip_o, start_o, ons}, {2'b00, 32'sd0})
        rd(A_CNT0 + 8'h8, 32'h1);
        wr(A_CTRL, 32'h21);
        rd(A_CNT0 + 8'h8, 32'h0);
        // enable low freezes the blocked state, high lets it go
        ce_i <= 1'b0;
        blk <= 1'b0;
        tick(40);
        `CHK(blocked_o, 1'b1)
        ce_i <= 1'b1;
        tick(8);
        `CHK(blocked_o, 1'b0)
        final_report();
    end
endmodule
`default_nettype wire
